// file: cfb_filter_bank.sv
`timescale 1ns/10ps
module cfb_filter_bank (
    input  wire logic                               clk,
    input  wire logic                               rst_n,
    input  wire logic                               ce,
    input  wire logic [cfb_pkg::ADDR_W-1:0]         reg_addr,
    input  wire logic                               reg_wr,
    input  wire logic                               reg_rd,
    input  wire logic [cfb_pkg::DATA_W-1:0]         reg_wdata,
    input  wire logic [cfb_pkg::NUM_CHAN-1:0]       chan_enable,
    output logic [cfb_pkg::DATA_W-1:0]              reg_rdata_q,
    output logic                                    reg_rvalid_q,
    output logic                                    conv_restart_q,
    output logic [1:0]                              first_chan_q,
    output cfb_pkg::cfb_cfg_t [cfb_pkg::NUM_CHAN-1:0]  chan_cfg_q,
    output cfb_pkg::cfb_rate_t [cfb_pkg::NUM_CHAN-1:0] chan_rate_q
);

    cfb_pkg::cfb_cfg_t [cfb_pkg::NUM_CHAN-1:0] chan_cfg_d;
    logic [cfb_pkg::DATA_W-1:0]                reg_rdata_d;
    logic                                      reg_rvalid_d;
    logic                                      conv_restart_d;
    logic [1:0]                                first_chan_d;
    logic [cfb_pkg::NUM_CHAN-1:0]              active;
    logic                                      hit_wr;
    logic                                      hit_rd;

    function automatic cfb_pkg::cfb_cfg_t unpack_word(input logic [cfb_pkg::DATA_W-1:0] w);
        cfb_pkg::cfb_cfg_t c;
        c.enhanced_rejection_enable = w[cfb_pkg::EN_BIT];
        c.enhanced_rejection_select = w[cfb_pkg::SEL_HI:cfb_pkg::SEL_LO];
        c.order                     = w[cfb_pkg::ORDER_HI:cfb_pkg::ORDER_LO];
        c.output_rate_code          = w[cfb_pkg::CODE_HI:cfb_pkg::CODE_LO];
        unpack_word = c;
    endfunction

    function automatic logic [cfb_pkg::DATA_W-1:0] pack_word(input cfb_pkg::cfb_cfg_t c);
        logic [cfb_pkg::DATA_W-1:0] w;
        w = '0;
        w[cfb_pkg::EN_BIT]                     = c.enhanced_rejection_enable;
        w[cfb_pkg::SEL_HI:cfb_pkg::SEL_LO]     = c.enhanced_rejection_select;
        w[cfb_pkg::ORDER_HI:cfb_pkg::ORDER_LO] = c.order;
        w[cfb_pkg::CODE_HI:cfb_pkg::CODE_LO]   = c.output_rate_code;
        pack_word = w;
    endfunction

    // lowest enabled channel, used both as readback source and sequence start
    function automatic logic [1:0] first_active(input logic [cfb_pkg::NUM_CHAN-1:0] en);
        logic [1:0] idx;
        idx = 2'h0;
        for (int i = cfb_pkg::NUM_CHAN - 1; i >= 0; i--) begin
            if (en[i]) begin
                idx = 2'(i);
            end
        end
        first_active = idx;
    endfunction

    always_comb begin
        active = chan_enable;
        if (chan_enable == '0) begin
            active[cfb_pkg::HV_CHAN] = 1'b1;
        end
    end

    assign hit_wr = reg_wr && (reg_addr == cfb_pkg::FILTER_CONFIG_ADDR);
    assign hit_rd = reg_rd && (reg_addr == cfb_pkg::FILTER_CONFIG_ADDR);

    always_comb begin
        chan_cfg_d = chan_cfg_q;
        for (int i = 0; i < cfb_pkg::NUM_CHAN; i++) begin
            if (hit_wr && active[i]) begin
                chan_cfg_d[i] = unpack_word(reg_wdata);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < cfb_pkg::NUM_CHAN; i++) begin
                chan_cfg_q[i] <= unpack_word(cfb_pkg::FILTER_CONFIG_RESET);
            end
        end else if (ce) begin
            chan_cfg_q <= chan_cfg_d;
        end
    end

    always_comb begin
        conv_restart_d = hit_wr;
        first_chan_d   = first_chan_q;
        if (hit_wr) begin
            first_chan_d = first_active(active);
        end
        reg_rvalid_d = hit_rd;
        reg_rdata_d  = reg_rdata_q;
        if (hit_rd) begin
            // readback shows the copy that a write would reach first
            reg_rdata_d = pack_word(chan_cfg_q[first_active(active)]);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_restart_q <= 1'b0;
            first_chan_q   <= 2'h0;
            reg_rvalid_q   <= 1'b0;
            reg_rdata_q    <= '0;
        end else if (ce) begin
            conv_restart_q <= conv_restart_d;
            first_chan_q   <= first_chan_d;
            reg_rvalid_q   <= reg_rvalid_d;
            reg_rdata_q    <= reg_rdata_d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < cfb_pkg::NUM_CHAN; g++) begin : g_dec
            cfb_rate_decode u_dec (
                .clk    (clk),
                .rst_n  (rst_n),
                .ce     (ce),
                .cfg    (chan_cfg_q[g]),
                .info_q (chan_rate_q[g])
            );
        end
    endgenerate

endmodule

// file: cfb_filter_bank_asserts.sv
`timescale 1ns/10ps
module cfb_filter_bank_chk (
    input wire logic                                    clk,
    input wire logic                                    rst_n,
    input wire logic                                    ce,
    input wire logic [cfb_pkg::ADDR_W-1:0]              reg_addr,
    input wire logic                                    reg_wr,
    input wire logic                                    reg_rd,
    input wire logic [cfb_pkg::DATA_W-1:0]              reg_wdata,
    input wire logic [cfb_pkg::NUM_CHAN-1:0]            chan_enable,
    input wire logic [cfb_pkg::DATA_W-1:0]              reg_rdata_q,
    input wire logic                                    reg_rvalid_q,
    input wire logic                                    conv_restart_q,
    input wire logic [1:0]                              first_chan_q,
    input wire cfb_pkg::cfb_cfg_t [cfb_pkg::NUM_CHAN-1:0]  chan_cfg_q,
    input wire cfb_pkg::cfb_rate_t [cfb_pkg::NUM_CHAN-1:0] chan_rate_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic        hit_wr;
    logic        hit_rd;
    logic [10:0] wpack;
    assign hit_wr = ce && reg_wr && reg_addr == cfb_pkg::FILTER_CONFIG_ADDR;
    assign hit_rd = ce && reg_rd && reg_addr == cfb_pkg::FILTER_CONFIG_ADDR;
    // reserved bits never reach the stored copy
    assign wpack = {reg_wdata[11:8], reg_wdata[6:0]};
    a_write_restart: assert property (hit_wr |=> conv_restart_q) else $error("restart missing");
    a_restart_cause: assert property (conv_restart_q |-> $past(hit_wr)) else $error("stray restart");
    a_read_valid: assert property (hit_rd |=> reg_rvalid_q) else $error("read unanswered");
    a_unmapped_quiet: assert property (!hit_rd |=> !reg_rvalid_q) else $error("stray rvalid");
    a_reserved_zero: assert property (reg_rvalid_q |-> reg_rdata_q[15:12] == 4'h0 && !reg_rdata_q[7])
        else $error("reserved bits set");
    a_hv_default: assert property (hit_wr && chan_enable == 4'h0 |=>
        first_chan_q == 2'h0 && chan_cfg_q[0] == $past(wpack)) else $error("hv default missed");
    a_sel_reserved: assert property (ce && chan_cfg_q[0].enhanced_rejection_enable &&
        chan_cfg_q[0].enhanced_rejection_select inside {3'h0, 3'h1, 3'h7} |=> !chan_rate_q[0].valid)
        else $error("reserved mode valid");
    a_order_reserved: assert property (ce && !chan_cfg_q[0].enhanced_rejection_enable &&
        chan_cfg_q[0].order inside {2'h1, 2'h2} |=> !chan_rate_q[0].valid) else $error("reserved order valid");
    for (genvar i = 0; i < cfb_pkg::NUM_CHAN; i++) begin : g_ch
        a_copy_active: assert property (hit_wr && chan_enable[i] |=> chan_cfg_q[i] == $past(wpack))
            else $error("copy missed");
        a_keep_other: assert property (!(hit_wr && (chan_enable[i] || (i == 0 && chan_enable == 4'h0)))
            |=> $stable(chan_cfg_q[i])) else $error("copy changed");
    end
    c_write: cover property (hit_wr ##1 conv_restart_q);
    c_read: cover property (hit_rd ##1 reg_rvalid_q);
    c_hv_default: cover property (hit_wr && chan_enable == 4'h0);
endmodule
bind cfb_filter_bank cfb_filter_bank_chk chk (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .chan_enable(chan_enable),
    .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .conv_restart_q(conv_restart_q),
    .first_chan_q(first_chan_q), .chan_cfg_q(chan_cfg_q), .chan_rate_q(chan_rate_q));

// file: cfb_host.sv
`timescale 1ns/10ps
module cfb_host (
    input  wire logic                    clk,
    output logic [cfb_pkg::ADDR_W-1:0]   reg_addr,
    output logic                         reg_wr,
    output logic                         reg_rd,
    output logic [cfb_pkg::DATA_W-1:0]   reg_wdata,
    output logic [cfb_pkg::NUM_CHAN-1:0] chan_enable
);
    initial begin
        reg_addr = 4'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
        chan_enable = 4'h0;
    end
    // one strobe cycle per access; address and data are inverted after release so stale values never match
    task automatic access(input logic wr, input logic rd, input logic [3:0] a, input logic [15:0] d,
        input logic [3:0] en);
        @(posedge clk);
        reg_wr <= wr;
        reg_rd <= rd;
        reg_addr <= a;
        reg_wdata <= d;
        chan_enable <= en;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
endmodule

// file: cfb_pkg.sv
package cfb_pkg;

    localparam int NUM_CHAN = 4;
    localparam int ADDR_W   = 4;
    localparam int DATA_W   = 16;
    localparam int RATE_W   = 24;
    localparam int CODE_W   = 5;
    localparam int SETTLE_W = 7;

    localparam logic [ADDR_W-1:0] FILTER_CONFIG_ADDR  = 4'h5;
    localparam logic [DATA_W-1:0] FILTER_CONFIG_RESET = 16'h0500;

    // field positions of the filter configuration word
    localparam int EN_BIT    = 11;
    localparam int SEL_HI    = 10;
    localparam int SEL_LO    = 8;
    localparam int ORDER_HI  = 6;
    localparam int ORDER_LO  = 5;
    localparam int CODE_HI   = 4;
    localparam int CODE_LO   = 0;
    localparam int HV_CHAN   = 0;

    localparam logic [1:0] ORDER_SINC5_SINC1 = 2'h0;
    localparam logic [1:0] ORDER_SINC3       = 2'h3;

    localparam logic [2:0] SEL_2727 = 3'h2;
    localparam logic [2:0] SEL_2500 = 3'h3;
    localparam logic [2:0] SEL_2067 = 3'h4;
    localparam logic [2:0] SEL_2000 = 3'h5;
    localparam logic [2:0] SEL_1667 = 3'h6;

    localparam logic [CODE_W-1:0] CODE_LAST = 5'h14;

    // rates are in hundredths of a sample per second
    localparam logic [RATE_W-1:0] ENH_RATE_2727 = 24'h000AA7;
    localparam logic [RATE_W-1:0] ENH_RATE_2500 = 24'h0009C4;
    localparam logic [RATE_W-1:0] ENH_RATE_2067 = 24'h000813;
    localparam logic [RATE_W-1:0] ENH_RATE_2000 = 24'h0007D0;
    localparam logic [RATE_W-1:0] ENH_RATE_1667 = 24'h000683;

    localparam logic [SETTLE_W-1:0] SETTLE_40_MS = 7'h28;
    localparam logic [SETTLE_W-1:0] SETTLE_50_MS = 7'h32;
    localparam logic [SETTLE_W-1:0] SETTLE_60_MS = 7'h3C;

    typedef logic [RATE_W-1:0] cfb_rate_tab_t [0:20];

    localparam cfb_rate_tab_t SINC3_RATE = '{
        24'hBEBC20, 24'hBEBC20, 24'h5F5E10, 24'h5F5E10, 24'h2FAF08, 24'h2625A0,
        24'h17D784, 24'h0FE524, 24'h07A120, 24'h03D090, 24'h0186A0, 24'h00C350,
        24'h009C7C, 24'h004E20, 24'h002724, 24'h001770, 24'h001388, 24'h0007D0,
        24'h000686, 24'h0003E8, 24'h0001F4};

    localparam cfb_rate_tab_t SINC5_RATE = '{
        24'hBEBC20, 24'hBEBC20, 24'h5F5E10, 24'h5F5E10, 24'h2FAF08, 24'h2625A0,
        24'h17D784, 24'h0FDA98, 24'h079EC8, 24'h03CFC8, 24'h0186A0, 24'h00C350,
        24'h009A7E, 24'h004E20, 24'h002724, 24'h001763, 24'h001380, 24'h0007D0,
        24'h000686, 24'h0003E8, 24'h0001F4};

    typedef struct packed {
        logic              enhanced_rejection_enable;
        logic [2:0]        enhanced_rejection_select;
        logic [1:0]        order;
        logic [CODE_W-1:0] output_rate_code;
    } cfb_cfg_t;

    typedef struct packed {
        logic                valid;
        logic [RATE_W-1:0]   rate;
        logic [SETTLE_W-1:0] settle_ms;
    } cfb_rate_t;

endpackage

// file: cfb_rate_decode.sv
`timescale 1ns/10ps
module cfb_rate_decode (
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic            ce,
    input  wire cfb_pkg::cfb_cfg_t cfg,
    output cfb_pkg::cfb_rate_t   info_q
);

    cfb_pkg::cfb_rate_t info_d;

    function automatic logic enh_sel_valid(input logic [2:0] sel);
        enh_sel_valid = (sel >= cfb_pkg::SEL_2727) && (sel <= cfb_pkg::SEL_1667);
    endfunction

    always_comb begin
        info_d = '0;
        if (cfg.enhanced_rejection_enable) begin
            // reserved mode codes give no rate rather than a guessed one
            info_d.valid = enh_sel_valid(cfg.enhanced_rejection_select);
            case (cfg.enhanced_rejection_select)
                cfb_pkg::SEL_2727: begin
                    info_d.rate = cfb_pkg::ENH_RATE_2727;
                end
                cfb_pkg::SEL_2500: begin
                    info_d.rate      = cfb_pkg::ENH_RATE_2500;
                    info_d.settle_ms = cfb_pkg::SETTLE_40_MS;
                end
                cfb_pkg::SEL_2067: begin
                    info_d.rate = cfb_pkg::ENH_RATE_2067;
                end
                cfb_pkg::SEL_2000: begin
                    info_d.rate      = cfb_pkg::ENH_RATE_2000;
                    info_d.settle_ms = cfb_pkg::SETTLE_50_MS;
                end
                cfb_pkg::SEL_1667: begin
                    info_d.rate      = cfb_pkg::ENH_RATE_1667;
                    info_d.settle_ms = cfb_pkg::SETTLE_60_MS;
                end
                default: begin
                    info_d.rate = '0;
                end
            endcase
        end else if (cfg.output_rate_code <= cfb_pkg::CODE_LAST) begin
            case (cfg.order)
                cfb_pkg::ORDER_SINC3: begin
                    info_d.valid = 1'b1;
                    info_d.rate  = cfb_pkg::SINC3_RATE[cfg.output_rate_code];
                end
                cfb_pkg::ORDER_SINC5_SINC1: begin
                    info_d.valid = 1'b1;
                    info_d.rate  = cfb_pkg::SINC5_RATE[cfg.output_rate_code];
                end
                default: begin
                    info_d.valid = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            info_q <= '0;
        end else if (ce) begin
            info_q <= info_d;
        end
    end

endmodule

// file: tb.sv
`timescale 1ns/10ps
module tb;
    logic                                           clk;
    logic                                           rst_n;
    logic                                           ce;
    logic [3:0]                                     reg_addr;
    logic                                           reg_wr;
    logic                                           reg_rd;
    logic [15:0]                                    reg_wdata;
    logic [3:0]                                     chan_enable;
    logic [15:0]                                    rdata;
    logic                                           rvalid;
    logic                                           restart;
    logic [1:0]                                     first;
    cfb_pkg::cfb_cfg_t [cfb_pkg::NUM_CHAN-1:0]      cfg;
    cfb_pkg::cfb_rate_t [cfb_pkg::NUM_CHAN-1:0]     rate;
    int                                             errors;
    int                                             n_tests;
    cfb_filter_bank uut (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .chan_enable(chan_enable), .reg_rdata_q(rdata),
        .reg_rvalid_q(rvalid), .conv_restart_q(restart), .first_chan_q(first), .chan_cfg_q(cfg), .chan_rate_q(rate));
    cfb_host host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .chan_enable(chan_enable));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic logic [10:0] pk(input logic [15:0] w);
        return {w[11:8], w[6:0]};
    endfunction
    task automatic check(input string n, input logic [63:0] s, input logic [63:0] e);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic t_reset();
        for (int i = 0; i < 4; i++) check("cfg", 32'(cfg[i]), 32'(pk(16'h0500)));
        check("rate", 32'(rate[0].rate), 32'h00BEBC20);
        host.access(1'b0, 1'b1, 4'h5, 16'h0000, 4'h0);
        #1 check("rdata", 32'(rdata), 32'h0500);
        check("rvalid", 32'(rvalid), 32'h1);
    endtask
    task automatic t_hv_default();
        host.access(1'b1, 1'b0, 4'h5, 16'hFFFF, 4'h0);
        #1 check("restart", 32'(restart), 32'h1);
        check("cfg0", 32'(cfg[0]), 32'(pk(16'hFFFF)));
        check("cfg1", 32'(cfg[1]), 32'(pk(16'h0500)));
        host.access(1'b0, 1'b1, 4'h5, 16'h0000, 4'h0);
        #1 check("rdata", 32'(rdata), 32'h0F7F);
        check("valid", 32'(rate[0].valid), 32'h0);
    endtask
    task automatic t_multi();
        host.access(1'b1, 1'b0, 4'h5, 16'h0070, 4'hA);
        #1 check("first", 32'(first), 32'h1);
        check("cfg", 64'({cfg[3], cfg[2], cfg[1], cfg[0]}),
            64'({pk(16'h0070), pk(16'h0500), pk(16'h0070), pk(16'hFFFF)}));
        host.access(1'b1, 1'b0, 4'h5, 16'h0010, 4'h1);
        #1 check("rate1", 32'(rate[1].rate), 32'h1388);
        @(posedge clk);
        #1 check("rate0", 32'(rate[0].rate), 32'h1380);
        host.access(1'b1, 1'b0, 4'h5, 16'h0007, 4'h1);
        @(posedge clk);
        #1 check("rate7", 32'(rate[0].rate), 32'h0FDA98);
    endtask
    task automatic t_enhanced();
        logic [23:0] r [0:5] = '{24'hBEBC20, 24'hAA7, 24'h9C4, 24'h813, 24'h7D0, 24'h683};
        logic [6:0]  s [0:5] = '{7'h00, 7'h00, 7'h28, 7'h00, 7'h32, 7'h3C};
        for (int k = 0; k < 6; k++) begin
            host.access(1'b1, 1'b0, 4'h5, (k == 0) ? 16'h0200 : 16'(12'h800 + (k + 1) * 256), 4'h1);
            @(posedge clk);
            #1 check("erate", 32'(rate[0].rate), 32'(r[k]));
            check("settle", 32'(rate[0].settle_ms), 32'(s[k]));
        end
    endtask
    task automatic t_refuse();
        host.access(1'b1, 1'b1, 4'h6, 16'h0000, 4'h1);
        #1 check("unmapped", 32'({restart, rvalid}), 32'h0);
        host.access(1'b1, 1'b0, 4'h5, 16'h0015, 4'h1);
        @(posedge clk);
        #1 check("code", 32'(rate[0].valid), 32'h0);
        host.access(1'b1, 1'b0, 4'h5, 16'h0840, 4'h1);
        @(posedge clk);
        #1 check("sel0", 32'(rate[0].valid), 32'h0);
        host.access(1'b1, 1'b0, 4'h5, 16'h0140, 4'h1);
        @(posedge clk);
        #1 check("order2", 32'(rate[0].valid), 32'h0);
        host.access(1'b1, 1'b0, 4'h5, 16'h0020, 4'h1);
        @(posedge clk);
        #1 check("order", 32'(rate[0].valid), 32'h0);
        @(posedge clk);
        ce <= 1'b0;
        host.access(1'b1, 1'b0, 4'h5, 16'h0000, 4'h1);
        #1 check("frozen", 32'({restart, cfg[0]}), 32'(pk(16'h0020)));
        @(posedge clk);
        ce <= 1'b1;
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        errors = 0;
        n_tests = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1 t_reset();
        t_hv_default();
        t_multi();
        t_enhanced();
        t_refuse();
        tally_and_finish();
    end
    // cuts a hang short
    initial begin
        #200000;
        errors++;
        tally_and_finish();
    end
endmodule
